// ==== prxtx_core.sv ====
// phy data path: 100M receive coding/alignment and 10M transmit encoding
//
// Contract
// - 100M logic runs only while the 125 MHz pll reports lock.
// - receive front end delivers one 6-bit quantized sample per line sample.
// - timing unit picks one of several clock phases as sampling strobe.
// - MLT-3 levels become an NRZI stream feeding the descrambler.
// - descrambler key syncs on idles, then holds and descrambles data.
// - no idle within 40 us aborts reception and restarts sync.
// - J-K pair fixes 5-bit boundaries until the next start of frame.
// - data groups map to nibbles; J-K yields two 0101 nibbles.
// - receive valid starts with the first preamble nibble of J-K.
// - T-R or two idles end carrier and valid, never emitted as data.
// - link failure or lost signal drops receive valid.
// - unexpected group in frame raises receive error.
// - bad start delimiter gives error with 1110, valid stays low.
// - without signal, receive clock comes from the reference clock.
// - MAC nibbles at 2.5 MHz with enable are serialized to 10 Mbps.
// - 10M serial stream is Manchester encoded on 20 MHz half bits.
// - with transmit enable low, normal link pulses are sent.
// - half duplex 10M loops transmit data back without collision.
// - heartbeat indication follows each 10M transmission.
// - J, K, T, R and idle code-groups have fixed patterns.
// - level change between symbols is 1, no change is 0.
`timescale 1ns/1ps
`default_nettype none
module prxtx_core
    import prxtx_pkg::*;
#(
    parameter int PHASES         = 8,
    parameter int NLP_PERIOD_CYC = prxtx_pkg::NLP_PERIOD_NS / prxtx_pkg::CLK_NS
) (
    input  wire logic                      clk,        // 40 MHz
    input  wire logic                      srst,       // sync reset
    input  wire logic                      speed_100,  // 1: 100M, 0: 10M
    input  wire logic                      full_duplex,// duplex mode
    input  wire logic                      pll_locked, // 125 MHz pll lock
    input  wire logic signed [5:0]         adc_sample, // quantized sample
    input  wire logic [PHASES-1:0]         phase_strobe,// phase strobes
    input  wire logic [$clog2(PHASES)-1:0] phase_sel,  // timing unit pick
    input  wire logic                      line_signal_present, // pin
    input  wire logic                      link_fail,  // link test failed
    input  wire logic                      col_detect, // pin, collision
    input  wire prxtx_pkg::prxtx_tx_nib_t  tx_mii,     // mac transmit
    output prxtx_pkg::prxtx_rx_nib_t       rx_mii,     // mac receive
    output logic                           crs,        // carrier sense
    output logic                           rx_clk,     // receive clock
    output logic                           tx_clk,     // 2.5 MHz tx clock
    output logic                           col,        // collision / sqe
    output prxtx_pkg::prxtx_tx_nib_t       loop_mii,   // 10M loopback
    output logic                           tx_line,    // line level
    output logic                           tx_line_en, // line driven
    output logic                           nlp_pulse   // link pulse on
);
    import prxtx_pkg::*;

    // ************************************************************
    // parameter checks
    // ************************************************************
    localparam int SQE_LO = SQE_DELAY_CYC;
    localparam int SQE_HI = SQE_DELAY_CYC + 3;
    generate
        if (PHASES < 2 || NLP_PERIOD_CYC <= 2 * NLP_WIDTH_CYC ||
            NLP_PERIOD_CYC >= (1 << NLP_W) || TX_NIB_CYC != 16 ||
            WINDOW_CYC >= (1 << WD_W)) begin : g_bad
            $error("prxtx_core: unsupported parameter value");
        end
    endgenerate

    // ************************************************************
    // input synchronisers
    // ************************************************************
    logic [1:0] async_in;
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] sync3;
    logic [1:0] filt;
    assign async_in = {col_detect, line_signal_present};
    // a change is accepted only once the second and third stages agree
    for (genvar g = 0; g < 2; g++) begin : g_sync
        always_ff @(posedge clk) begin
            if (srst) begin
                sync1[g] <= 1'b0;
                sync2[g] <= 1'b0;
                sync3[g] <= 1'b0;
                filt[g]  <= 1'b0;
            end else begin
                sync1[g] <= async_in[g];
                sync2[g] <= sync1[g];
                sync3[g] <= sync2[g];
                if (sync2[g] == sync3[g]) begin
                    filt[g] <= sync3[g];
                end
            end
        end
    end
    logic sig_ok;
    logic col_s;
    assign sig_ok = filt[0];
    assign col_s  = filt[1];

    // ************************************************************
    // 100M symbol recovery
    // ************************************************************
    logic       bit_tick;
    logic [1:0] lvl;
    logic [1:0] prev_lvl;
    logic       nrz;
    // phase mux steered by timing unit, gated by pll lock
    assign bit_tick = speed_100 & pll_locked & phase_strobe[phase_sel];
    // 6-bit sample sliced to three mlt-3 levels
    always_comb begin
        if (adc_sample > MLT_THRESH) begin
            lvl = 2'b01;
        end else if (adc_sample < -MLT_THRESH) begin
            lvl = 2'b11;
        end else begin
            lvl = 2'b00;
        end
    end
    assign nrz = (lvl != prev_lvl);
    always_ff @(posedge clk) begin
        if (srst) begin
            prev_lvl <= 2'b00;
        end else if (bit_tick) begin
            prev_lvl <= lvl;
        end
    end

    // ************************************************************
    // descrambler and idle watchdog
    // ************************************************************
    logic [KEY_W-1:0] key;
    logic             key_bit;
    logic             locked;
    logic [4:0]       match_cnt;
    logic             descr;
    logic [3:0]       one_run;
    logic [WD_W-1:0]  wd_cnt;
    logic             wd_abort;
    assign key_bit  = key[KEY_TAP_A] ^ key[KEY_TAP_B];
    assign descr    = nrz ^ key_bit;
    assign wd_abort = locked && (wd_cnt == WD_W'(WINDOW_CYC - 1));
    // unlocked: idles descramble to ones, so the key is the inverted line
    always_ff @(posedge clk) begin
        if (srst) begin
            key       <= '0;
            locked    <= 1'b0;
            match_cnt <= '0;
        end else if (wd_abort || !sig_ok) begin
            locked    <= 1'b0;
            match_cnt <= '0;
        end else if (bit_tick) begin
            if (locked) begin
                key <= {key[KEY_W-2:0], key_bit};
            end else begin
                key <= {key[KEY_W-2:0], ~nrz};
                match_cnt <= (~nrz == key_bit) ? match_cnt + 5'h01 : 5'h00;
                locked    <= (match_cnt == LOCK_BITS);
            end
        end
    end
    // a run of ones counts as an idle; counting cycles is simpler than bits
    always_ff @(posedge clk) begin
        if (srst || !locked) begin
            one_run <= '0;
            wd_cnt  <= '0;
        end else begin
            if (bit_tick) begin
                one_run <= descr ? ((one_run == IDLE_RUN) ? one_run
                                    : one_run + 4'h1) : 4'h0;
            end
            wd_cnt <= (one_run == IDLE_RUN) ? '0 : wd_cnt + WD_W'(1);
        end
    end

    // ************************************************************
    // code-group alignment and 5b/4b decode
    // ************************************************************
    prxtx_rx_state_t state;
    prxtx_pend_t     pend;
    prxtx_rx_nib_t   stage;
    logic [9:0]      next_sh;
    logic [9:0]      grp_sh;
    logic [2:0]      bit_phase;
    logic            grp_done;
    logic            live;
    logic [4:0]      cur;
    logic [4:0]      dec;
    logic            end_hit;
    assign next_sh  = {grp_sh[8:0], descr};
    assign cur      = next_sh[4:0];
    assign dec      = prxtx_decode(cur);
    assign live     = sig_ok & ~link_fail & ~wd_abort;
    assign grp_done = bit_tick && locked && (bit_phase == CG_LAST);
    assign end_hit  = (pend == PEND_T && cur == R_CG) ||
                      (pend == PEND_I && cur == IDLE_CG);
    // bit counter restarts at a J preceded by idle, held through the frame
    always_ff @(posedge clk) begin
        if (srst) begin
            grp_sh    <= '0;
            bit_phase <= '0;
        end else if (bit_tick && locked) begin
            grp_sh <= next_sh;
            if (state == RX_HUNT && next_sh == {IDLE_CG, J_CG}) begin
                bit_phase <= '0;
            end else begin
                bit_phase <= (bit_phase == CG_LAST) ? 3'h0 : bit_phase + 3'h1;
            end
        end
    end
    // one group of latency lets T and idle be held back until confirmed
    always_ff @(posedge clk) begin
        if (srst || !live) begin
            state  <= RX_HUNT;
            pend   <= PEND_NONE;
            stage  <= '0;
            rx_mii <= '0;
            crs    <= 1'b0;
        end else if (bit_tick && locked && state == RX_HUNT &&
                     next_sh == {IDLE_CG, J_CG}) begin
            state <= RX_SSD;
            crs   <= 1'b1;
        end else if (grp_done) begin
            unique case (state)
                RX_HUNT: begin
                    rx_mii <= '0;
                end
                RX_SSD: begin
                    if (cur == K_CG) begin
                        rx_mii <= '{dv: 1'b1, er: 1'b0, nib: NIB_PRE};
                        stage  <= '{dv: 1'b1, er: 1'b0, nib: NIB_PRE};
                        pend   <= PEND_NONE;
                        state  <= RX_FRAME;
                    end else begin
                        rx_mii <= '{dv: 1'b0, er: 1'b1, nib: NIB_BAD};
                        state  <= RX_HUNT;
                        crs    <= 1'b0;
                    end
                end
                RX_FRAME: begin
                    if (end_hit) begin
                        rx_mii <= '0;
                        crs    <= 1'b0;
                        pend   <= PEND_NONE;
                        state  <= RX_HUNT;
                    end else begin
                        rx_mii <= (pend != PEND_NONE) ?
                            '{dv: 1'b1, er: 1'b1, nib: NIB_ERR} : stage;
                        if (cur == T_CG) begin
                            pend <= PEND_T;
                        end else if (cur == IDLE_CG) begin
                            pend <= PEND_I;
                        end else begin
                            pend  <= PEND_NONE;
                            stage <= '{dv: 1'b1, er: ~dec[4], nib: dec[3:0]};
                        end
                    end
                end
                default: begin
                    state <= RX_HUNT;
                end
            endcase
        end
    end

    // ************************************************************
    // receive clock
    // ************************************************************
    logic ref_div;
    // recovered from group timing, else a divided reference clock
    always_ff @(posedge clk) begin
        if (srst) begin
            ref_div <= 1'b0;
            rx_clk  <= 1'b0;
        end else begin
            ref_div <= ~ref_div;
            rx_clk  <= (sig_ok && locked) ? (bit_phase < CLK_HI)
                                          : ref_div;
        end
    end

    // ************************************************************
    // 10M transmit
    // ************************************************************
    logic [3:0]       tx_cnt;
    logic [3:0]       tx_sh;
    logic             tx_active;
    logic             prev_active;
    logic             cur_tx_bit;
    logic             lb_next;
    logic [NLP_W-1:0] nlp_cnt;
    logic             nlp_on;
    logic [SQE_W-1:0] sqe_cnt;
    logic             sqe_run;
    logic             sqe_on;
    assign cur_tx_bit = tx_sh[tx_cnt[3:2]];
    assign lb_next    = tx_active & ~full_duplex;
    assign nlp_on     = ~tx_active && nlp_cnt < NLP_W'(NLP_WIDTH_CYC);
    // nibble taken at the end of each 16-cycle slot, mac drives on tx_clk
    always_ff @(posedge clk) begin
        if (srst) begin
            tx_cnt      <= '0;
            tx_sh       <= '0;
            tx_active   <= 1'b0;
            prev_active <= 1'b0;
            tx_clk      <= 1'b0;
        end else begin
            tx_cnt      <= tx_cnt + 4'h1;
            tx_clk      <= ~tx_cnt[3];
            prev_active <= tx_active;
            if (tx_cnt == 4'hf) begin
                tx_sh     <= tx_mii.nib;
                tx_active <= ~speed_100 & tx_mii.en;
            end
        end
    end
    // first half carries the inverse, second half the bit
    always_ff @(posedge clk) begin
        if (srst) begin
            tx_line    <= 1'b0;
            tx_line_en <= 1'b0;
            nlp_pulse  <= 1'b0;
        end else begin
            tx_line    <= tx_active ? (tx_cnt[1] ? cur_tx_bit : ~cur_tx_bit)
                                    : (nlp_on & ~speed_100);
            tx_line_en <= tx_active | (nlp_on & ~speed_100);
            nlp_pulse  <= nlp_on & ~speed_100;
        end
    end
    // pulse period counter runs only while the transmitter is idle
    always_ff @(posedge clk) begin
        if (srst || tx_active || speed_100) begin
            nlp_cnt <= '0;
        end else begin
            nlp_cnt <= (nlp_cnt == NLP_W'(NLP_PERIOD_CYC - 1)) ? '0
                                                            : nlp_cnt + NLP_W'(1);
        end
    end
    // heartbeat window after the end of each transmission
    always_ff @(posedge clk) begin
        if (srst || speed_100 || tx_active) begin
            sqe_run <= 1'b0;
            sqe_cnt <= '0;
            sqe_on  <= 1'b0;
        end else begin
            if (prev_active) begin
                sqe_run <= 1'b1;
                sqe_cnt <= '0;
            end else if (sqe_run) begin
                sqe_cnt <= sqe_cnt + SQE_W'(1);
                sqe_run <= (sqe_cnt != SQE_W'(SQE_DELAY_CYC + SQE_WIDTH_CYC));
            end
            sqe_on <= sqe_run && sqe_cnt >= SQE_W'(SQE_DELAY_CYC) &&
                      sqe_cnt < SQE_W'(SQE_DELAY_CYC + SQE_WIDTH_CYC);
        end
    end
    // loopback never counts as collision; real collisions masked meanwhile
    always_ff @(posedge clk) begin
        if (srst) begin
            loop_mii <= '0;
            col      <= 1'b0;
        end else begin
            loop_mii <= '{en: lb_next, nib: tx_sh};
            col      <= ~lb_next & (sqe_on | (~full_duplex & col_s));
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    a_ssd_preamble: assert property (@(posedge clk) disable iff (srst)
        (state == RX_SSD && grp_done && cur == K_CG && live)
        |=> (rx_mii.dv && rx_mii.nib == 4'h5 && crs))
        else $error("preamble nibble missing after start delimiter");
    a_bad_ssd_code: assert property (@(posedge clk) disable iff (srst)
        (state == RX_SSD && grp_done && cur != K_CG && live)
        |=> (rx_mii.er && !rx_mii.dv && rx_mii.nib == 4'he))
        else $error("bad start delimiter not flagged");
    a_sig_loss_drop: assert property (@(posedge clk) disable iff (srst)
        (!sig_ok || link_fail) |=> (!rx_mii.dv && !crs))
        else $error("receive valid held after signal loss");
    a_watchdog_abort: assert property (@(posedge clk) disable iff (srst)
        wd_abort |=> (!locked && !rx_mii.dv && state == RX_HUNT))
        else $error("idle watchdog did not abort");
    a_end_delim: assert property (@(posedge clk) disable iff (srst)
        (state == RX_FRAME && grp_done && end_hit && live)
        |=> (!rx_mii.dv && !crs))
        else $error("end delimiter did not close frame");
    a_tx_clk_period: assert property (@(posedge clk) disable iff (srst)
        $rose(tx_clk) |-> ##16 $rose(tx_clk))
        else $error("transmit nibble clock period wrong");
    a_manch_halves: assert property (@(posedge clk) disable iff (srst)
        (tx_active && $past(tx_active, 3) && tx_cnt[1:0] == 2'd3)
        |-> (tx_line != $past(tx_line, 2)))
        else $error("manchester halves not complementary");
    a_nlp_width: assert property (@(posedge clk)
        disable iff (srst || tx_active || speed_100)
        $rose(nlp_pulse) |-> nlp_pulse[*4] ##1 !nlp_pulse)
        else $error("link pulse width wrong");
    a_loop_no_col: assert property (@(posedge clk) disable iff (srst)
        loop_mii.en |-> !col)
        else $error("collision raised during loopback");
    a_sqe_after_tx: assert property (@(posedge clk)
        disable iff (srst || speed_100 || tx_active)
        $fell(tx_active) |-> ##[SQE_LO:SQE_HI] col)
        else $error("heartbeat missing after transmission");

endmodule : prxtx_core
`default_nettype wire

// ==== prxtx_core_tb.sv ====
// testbench: 100M receive coding and 10M transmit of the phy
`timescale 1ns/1ps
`default_nettype none
module prxtx_core_tb;
    import prxtx_pkg::*;
    logic              clk = 0, srst = 1, sp100 = 1, lfail = 0, go = 0;
    logic              pll = 1, sigp = 1;
    logic [7:0]        stb = '0, nibs = '0;
    logic signed [5:0] adc = '0;
    logic [10:0]       key = 11'h7ff;
    int                p = 0, err_total = 0, check_count = 0;
    prxtx_tx_nib_t     tx_mii, loop_mii;
    prxtx_rx_nib_t     rx_mii;
    logic              crs, tx_clk, col, tx_line, tx_line_en, nlp, rxc;
    always #12.5 clk = ~clk;
    prxtx_core #(.PHASES(8), .NLP_PERIOD_CYC(64)) DUT (
        .clk(clk), .srst(srst), .speed_100(sp100), .full_duplex(1'b0),
        .pll_locked(pll), .adc_sample(adc), .phase_strobe(stb),
        .phase_sel(3'h3), .line_signal_present(sigp), .link_fail(lfail),
        .col_detect(1'b0), .tx_mii(tx_mii), .rx_mii(rx_mii), .crs(crs),
        .rx_clk(rxc), .tx_clk(tx_clk), .col(col), .loop_mii(loop_mii),
        .tx_line(tx_line), .tx_line_en(tx_line_en), .nlp_pulse(nlp));
    prxtx_mac_model MAC (.clk(clk), .tx_clk(tx_clk), .go(go),
        .nibs(nibs), .tx_mii(tx_mii));
    task automatic cmp_nib(string w, prxtx_rx_nib_t e, prxtx_rx_nib_t g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s exp %h got %h", w, e, g);
        end
    endtask : cmp_nib
    task automatic cmp_bit(string w, logic e, logic g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s exp %b got %b", w, e, g);
        end
    endtask : cmp_bit
    // scramble, then mlt-3 code one bit; strobes two clocks apart
    task automatic send_bit(logic b);
        logic s;
        s = key[10] ^ key[8];
        key = {key[9:0], s};
        if (b ^ s) p = (p + 1) % 4;
        adc = (p == 1) ? 6'sd20 : (p == 3) ? -6'sd20 : 6'sd0;
        stb = 8'h08;
        @(negedge clk);
        stb = '0;
        @(negedge clk);
    endtask : send_bit
    task automatic send_cg(logic [4:0] cg, int n = 1);
        repeat (n) for (int i = 4; i >= 0; i--) send_bit(cg[i]);
    endtask : send_cg
    // lock on idles, then J K 3 A and T R or two idles
    task automatic frame_ok(logic idle_end);
        send_cg(5'h1f, 24);
        send_cg(5'h18);
        send_cg(5'h11);
        cmp_nib("jk1", '{1'b1, 1'b0, 4'h5}, rx_mii);
        cmp_bit("crs", 1'b1, crs);
        cmp_bit("rxclk", 1'b1, rxc);
        @(negedge clk);
        cmp_bit("rxclk", 1'b1, rxc);
        send_cg(5'h15);
        cmp_nib("jk2", '{1'b1, 1'b0, 4'h5}, rx_mii);
        send_cg(5'h16);
        cmp_nib("d3", '{1'b1, 1'b0, 4'h3}, rx_mii);
        send_cg(idle_end ? 5'h1f : 5'h0d);
        cmp_nib("da", '{1'b1, 1'b0, 4'ha}, rx_mii);
        send_cg(idle_end ? 5'h1f : 5'h07);
        cmp_bit("dv", 1'b0, rx_mii.dv);
        cmp_bit("crs", 1'b0, crs);
    endtask : frame_ok
    // link test failure or signal loss in mid frame
    task automatic frame_cut(logic by_sig);
        logic b0;
        send_cg(5'h1f, 24);
        send_cg(5'h18);
        send_cg(5'h11);
        send_cg(5'h15);
        cmp_bit("dvin", 1'b1, rx_mii.dv);
        sigp = ~by_sig;
        lfail = ~by_sig;
        repeat (8) @(negedge clk);
        cmp_bit("dv", 1'b0, rx_mii.dv);
        cmp_bit("crsc", 1'b0, crs);
        b0 = rxc;
        @(negedge clk);
        cmp_bit("rxclk", b0 ^ by_sig, rxc);
        sigp = 1'b1;
        lfail = 1'b0;
        repeat (8) @(negedge clk);
    endtask : frame_cut
    // J, a group lost while the pll is out, then data instead of K
    task automatic bad_ssd();
        logic [10:0] k0;
        int          p0;
        send_cg(5'h1f, 24);
        send_cg(5'h18);
        k0 = key;
        p0 = p;
        pll = 0;
        send_cg(5'h15);
        cmp_bit("pll", 1'b1, crs);
        cmp_nib("pll", '{1'b0, 1'b0, 4'h0}, rx_mii);
        key = k0;
        p = p0;
        pll = 1;
        send_cg(5'h15);
        cmp_nib("ssd", '{1'b0, 1'b1, 4'he}, rx_mii);
    endtask : bad_ssd
    // a long frame fits the idle window, a longer one is cut
    task automatic idle_watch();
        send_cg(5'h1f, 24);
        send_cg(5'h18);
        send_cg(5'h11);
        send_cg(5'h15, 150);
        cmp_nib("long", '{1'b1, 1'b0, 4'h3}, rx_mii);
        send_cg(5'h15, 20);
        cmp_nib("cut", '{1'b0, 1'b0, 4'h0}, rx_mii);
        cmp_bit("crsw", 1'b0, crs);
    endtask : idle_watch
    // two nibbles out at 10M, then heartbeat and a link pulse
    task automatic tx10();
        sp100 = 0;
        nibs = 8'hc1;
        go = 1;
        for (int k = 0; k < 60 && loop_mii.en !== 1'b1; k++) @(negedge clk);
        cmp_bit("loop", 1'b1, loop_mii.en);
        for (int k = 0; k < 32; k++) begin
            cmp_bit("line", nibs[k/4] ^ (k % 4 < 2), tx_line);
            if (k % 8 == 0) cmp_bit("txclk", k % 16 == 0, tx_clk);
            if (k == 1) cmp_bit("lpn", 1'b1, loop_mii.nib === 4'h1);
            cmp_bit("col", 1'b0, col);
            @(negedge clk);
        end
        go = 0;
        for (int k = 0; k < 150 && col !== 1'b1; k++) @(negedge clk);
        cmp_bit("sqe", 1'b1, col);
        for (int k = 0; k < 150 && nlp !== 1'b1; k++) @(negedge clk);
        cmp_bit("nlp", 1'b1, tx_line_en);
        cmp_bit("nlpl", 1'b1, tx_line);
        repeat (4) @(negedge clk);
        cmp_bit("nlpw", 1'b0, nlp);
    endtask : tx10
    task automatic close_out();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out
    initial begin
        repeat (12) @(negedge clk);
        srst = 0;
        frame_ok(1'b0);
        frame_ok(1'b1);
        frame_cut(1'b0);
        frame_cut(1'b1);
        bad_ssd();
        idle_watch();
        tx10();
        close_out();
    end
    // watchdog: the whole run needs about four thousand cycles
    initial begin
        #(25 * 20000);
        err_total++;
        close_out();
    end
endmodule : prxtx_core_tb
`default_nettype wire

// ==== prxtx_mac_model.sv ====
// mac side model: drives two transmit nibbles on the internal mii
`timescale 1ns/1ps
`default_nettype none
module prxtx_mac_model
    import prxtx_pkg::*;
(
    input  wire logic                    clk,    // system clock
    input  wire logic                    tx_clk, // nibble clock
    input  wire logic                    go,     // start a burst
    input  wire logic [7:0]              nibs,   // low nibble first
    output var prxtx_pkg::prxtx_tx_nib_t tx_mii  // to the phy
);
    // change just after tx_clk rises, clear of the sampling slot
    initial begin
        tx_mii = '0;
        forever begin
            @(posedge go);
            for (int i = 0; i < 2; i++) begin
                @(posedge tx_clk);
                @(negedge clk);
                tx_mii = '{1'b1, nibs[4*i +: 4]};
            end
            @(posedge tx_clk);
            @(negedge clk);
            // released bus shows the inverse, never a stale nibble
            tx_mii = '{1'b0, ~nibs[7:4]};
        end
    end
endmodule : prxtx_mac_model
`default_nettype wire

// ==== prxtx_pkg.sv ====
// package: constants, carrier types and code tables of the phy line path
package prxtx_pkg;

    // ************************************************************
    // clock and timing
    // ************************************************************
    localparam int CLK_NS        = 25;
    localparam int WINDOW_NS     = 40000;
    localparam int WINDOW_CYC    = WINDOW_NS / CLK_NS;
    localparam int WD_W          = 11;
    localparam int TX_NIB_NS     = 400;
    localparam int TX_NIB_CYC    = TX_NIB_NS / CLK_NS;
    localparam int NLP_PERIOD_NS = 16000000;
    localparam int NLP_WIDTH_NS  = 100;
    localparam int NLP_WIDTH_CYC = (NLP_WIDTH_NS + CLK_NS - 1) / CLK_NS;
    localparam int NLP_W         = 20;
    localparam int SQE_DELAY_NS  = 1000;
    localparam int SQE_DELAY_CYC = (SQE_DELAY_NS + CLK_NS - 1) / CLK_NS;
    localparam int SQE_WIDTH_NS  = 1000;
    localparam int SQE_WIDTH_CYC = (SQE_WIDTH_NS + CLK_NS - 1) / CLK_NS;
    localparam int SQE_W         = 7;

    // ************************************************************
    // receive coding
    // ************************************************************
    localparam int                SAMPLE_W   = 6;
    localparam logic signed [5:0] MLT_THRESH = 6'sh10;
    localparam logic [4:0] J_CG    = 5'h18;
    localparam logic [4:0] K_CG    = 5'h11;
    localparam logic [4:0] T_CG    = 5'h0d;
    localparam logic [4:0] R_CG    = 5'h07;
    localparam logic [4:0] IDLE_CG = 5'h1f;
    localparam logic [3:0] NIB_PRE = 4'h5;
    localparam logic [3:0] NIB_BAD = 4'he;
    localparam logic [3:0] NIB_ERR = 4'h0;
    localparam logic [2:0] CG_LAST = 3'h4;
    localparam logic [2:0] CLK_HI  = 3'h2;
    localparam int KEY_W     = 11;
    localparam int KEY_TAP_A = 10;
    localparam int KEY_TAP_B = 8;
    localparam logic [4:0] LOCK_BITS = 5'h1e;
    localparam logic [3:0] IDLE_RUN  = 4'ha;
    localparam logic [4:0] DATA_CG [16] = '{
        5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
        5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};

    typedef enum logic [1:0] {
        RX_HUNT  = 2'b00,
        RX_SSD   = 2'b01,
        RX_FRAME = 2'b10
    } prxtx_rx_state_t;

    typedef enum logic [1:0] {
        PEND_NONE = 2'b00,
        PEND_T    = 2'b01,
        PEND_I    = 2'b10
    } prxtx_pend_t;

    typedef struct packed {
        logic       dv;
        logic       er;
        logic [3:0] nib;
    } prxtx_rx_nib_t;

    typedef struct packed {
        logic       en;
        logic [3:0] nib;
    } prxtx_tx_nib_t;

    // data code-group to {valid, nibble}
    function automatic logic [4:0] prxtx_decode(input logic [4:0] cg);
        logic [4:0] res;
        res = {1'b0, NIB_ERR};
        for (int i = 0; i < 16; i++) begin
            if (cg == DATA_CG[i]) begin
                res = {1'b1, 4'(i)};
            end
        end
        return res;
    endfunction : prxtx_decode

endpackage : prxtx_pkg
